// >>> common/ssfp_pkg.sv
// package: register map, field positions, modes and timing of the sync serial block
package ssfp_pkg;
  localparam int SSFP_AW = 12;
  localparam int SSFP_DW = 32;
  localparam logic [SSFP_AW-1:0] SSFP_PARAM_OFS  = 12'h000;
  localparam logic [SSFP_AW-1:0] SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS  = 12'h004;
  localparam logic [SSFP_AW-1:0] SSFP_TXDATA_OFS = 12'h008;
  localparam logic [SSFP_AW-1:0] SSFP_RXSTAT_OFS = 12'h00C;
  // line parameter fields
  localparam int SSFP_PR_MODE = 12;
  localparam int SSFP_PR_WLEN = 10;
  localparam int SSFP_PR_PEN  = 9;
  localparam int SSFP_PR_PSEN = 8;
  localparam int SSFP_PR_SYNC = 0;
  localparam logic [15:0] SSFP_PARAM_RST = 16'h0000;
  // transmit control and flags fields
  localparam int SSFP_TX_FILL   = 15;
  localparam int SSFP_TX_MDATA  = 14;
  localparam int SSFP_TX_SSCLK  = 13;
  localparam int SSFP_TX_LOOP   = 11;
  localparam int SSFP_TX_RXMON  = 10;
  localparam int SSFP_TX_MCLR   = 8;
  localparam int SSFP_TX_DONE   = 7;
  localparam int SSFP_TX_TXIE   = 6;
  localparam int SSFP_TX_FILLIE = 5;
  localparam int SSFP_TX_SEND   = 4;
  localparam int SSFP_TX_BRK    = 0;
  localparam logic [15:0] SSFP_TRANSMIT_CONTROL_AND_FLAGS_RW  = 16'h7879;
  localparam logic [15:0] SSFP_TRANSMIT_CONTROL_AND_FLAGS_RST = 16'h0000;
  // receive status fields
  localparam int SSFP_RX_PERR = 8;
  localparam int SSFP_RX_DONE = 9;
  localparam int SSFP_RX_LOCK = 10;
  // character and timing
  localparam logic [3:0] SSFP_MIN_BITS = 4'h5;
  localparam logic [3:0] SSFP_MAX_FRAME = 4'h9;
  localparam int SSFP_CHAR_W = 8;
  localparam int SSFP_FIFO_DEPTH = 16;
  localparam int SSFP_SYS_CLK_HZ = 50_000_000;
  localparam int SSFP_BIT_RATE_HZ = 9600;
  localparam int SSFP_BIT_CYCLES = SSFP_SYS_CLK_HZ / SSFP_BIT_RATE_HZ;
  typedef enum logic [1:0] {
    SSFP_MODE_ISO = 2'b00,
    SSFP_MODE_BAD = 2'b01,
    SSFP_MODE_EXT = 2'b10,
    SSFP_MODE_INT = 2'b11
  } ssfp_mode_e;
  typedef enum logic [1:0] {
    SSFP_LOOP_NORMAL = 2'b00,
    SSFP_LOOP_INT    = 2'b01,
    SSFP_LOOP_EXT    = 2'b10,
    SSFP_LOOP_TEST   = 2'b11
  } ssfp_loop_e;
  typedef enum logic {
    SSFP_RX_HUNT   = 1'b0,
    SSFP_RX_LOCKED = 1'b1
  } ssfp_rx_e;
endpackage

// >>> common/ssfp_fifo_if.sv
// interface: transmit character queue between register side and fifo
`timescale 1ns/1ps
`default_nettype none
interface ssfp_fifo_if #(parameter int W = 8) ();
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  logic         flush;
  modport user (output push_valid, push_data, pop_ready, flush,
                input  push_ready, pop_valid, pop_data);
  modport fifo (input  push_valid, push_data, pop_ready, flush,
                output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// >>> hdl/ssfp_fifo.sv
// module: transmit character fifo, depth a power of two
`timescale 1ns/1ps
`default_nettype none
module ssfp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  ssfp_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         full;
  logic         empty;

  assign full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign q.push_ready = !full;
  assign q.pop_valid  = !empty;
  assign q.pop_data   = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
    end else if (q.flush) begin
      wr_ptr <= '0;
    end else if (q.push_valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= '0;
    end else if (q.flush) begin
      rd_ptr <= '0;
    end else if (q.pop_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage has no reset: only slots behind the pointers are ever read
  always_ff @(posedge pclk) begin
    if (q.push_valid && !full && !q.flush) begin
      mem[wr_ptr[AW-1:0]] <= q.push_data;
    end
  end
endmodule // ssfp_fifo
`default_nettype wire

// >>> hdl/ssfp_top.sv
// module: sync serial transmitter/receiver with parity, sync and fill, apb slave
// How it works
// R1 - parity sense one even, zero odd
// R2 - transmitter appends parity bit itself
// R3 - receiver hunts sync character for framing
// R4 - late data in sync mode sends fill
// R5 - software loads within one character time
// R6 - fill sets fill flag, sync modes only
// R7 - fill flag with enable raises irq
// R8 - fill flag read-only, cleared by reads
// R9 - transmit status register bit layout
// R10 - unused status bits read zero; bit 3 is writable here and reads back what was written
// R11 - data resumes at character boundary only
// R12 - mode field selects clocking, others erroneous
// R13 - done set by start, cleared by load
// R14 - done with enable raises irq
// R15 - loop select picks maintenance mode
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ssfp_top #(
  parameter int unsigned BIT_CYCLES = ssfp_pkg::SSFP_BIT_CYCLES,
  parameter int          FIFO_DEPTH = ssfp_pkg::SSFP_FIFO_DEPTH
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ssfp_pkg::SSFP_AW-1:0] paddr,
  input  wire logic [ssfp_pkg::SSFP_DW-1:0] pwdata,
  output logic      [ssfp_pkg::SSFP_DW-1:0] prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         modem_clk,
  input  wire logic                         rx_line,
  output logic                              tx_line,
  output logic                              tx_irq
);
  import ssfp_pkg::*;
  localparam int DW = $clog2(BIT_CYCLES + 1);

  ssfp_fifo_if #(.W(SSFP_CHAR_W)) txq ();

  logic [15:0] param_reg;
  logic [15:0] ctl;
  logic        fill_sent_flag;
  logic        done;
  logic        acc;
  logic        setup;
  logic        wr_data;
  logic        wr_en;
  logic        clr;
  logic        status_read_strobe;
  logic        rxstat_read;
  logic        unmapped;
  logic [15:0] rd_word;
  logic        mclk_s1;
  logic        mclk_s2;
  logic        mclk_s3;
  logic        rx_s1;
  logic        rx_s2;
  logic        ss_prev;
  logic [DW-1:0] div_cnt;
  logic        div_tick;
  logic        bit_tick;
  ssfp_mode_e  mode;
  ssfp_loop_e  loop_mode_select;
  logic [7:0]  sync_char;
  logic [1:0]  wlen;
  logic        par_en;
  logic        parity_sense_select;
  logic [3:0]  nbits;
  logic [3:0]  flen;
  logic [8:0]  fmask;
  logic        sync_mode;
  logic        send_en;
  logic [8:0]  tx_sh;
  logic [3:0]  tx_left;
  logic        tx_bit;
  logic        boundary;
  logic        char_start;
  logic        fill_start;
  logic [8:0]  tx_frame;
  logic [8:0]  sync_frame;
  logic        rx_in;
  ssfp_rx_e    rx_state;
  logic [8:0]  rx_win;
  logic [8:0]  next_win;
  logic [8:0]  rx_frame;
  logic [3:0]  rx_cnt;
  logic [7:0]  rx_data;
  logic        rx_perr;
  logic        rx_done;
  logic        rx_char;
  logic        rx_match;
  logic [8:0]  par_mask;

  // data bits, parity at bit n; even sense gives an even count of ones
  function automatic logic [8:0] ssfp_frame(input logic [7:0] d, input logic [3:0] n,
                                            input logic pen, input logic psen);
    logic [8:0] f;
    logic       p;
    f = '0;
    p = ~psen;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(n)) begin
        f[i] = d[i];
        p = p ^ d[i];
      end
    end
    if (pen) begin
      f[n] = p;
    end
    return f;
  endfunction

  ssfp_fifo #(
    .W     (SSFP_CHAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (txq)
  );

  // apb decode; a data write waits while the fifo is full
  assign acc      = psel && penable;
  assign setup    = psel && !penable;
  assign wr_data  = acc && pwrite && (paddr == SSFP_TXDATA_OFS);
  assign pready   = !(wr_data && !txq.push_ready);
  assign wr_en    = acc && pwrite && pready;
  assign clr      = wr_en && (paddr == SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS) && pwdata[SSFP_TX_MCLR];
  assign status_read_strobe = acc && !pwrite && pready && (paddr == SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS);
  assign rxstat_read = acc && !pwrite && pready && (paddr == SSFP_RXSTAT_OFS);
  assign unmapped = (paddr != SSFP_PARAM_OFS) && (paddr != SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS) &&
                    (paddr != SSFP_TXDATA_OFS) && (paddr != SSFP_RXSTAT_OFS);
  assign txq.push_valid = wr_data;
  assign txq.push_data  = pwdata[SSFP_CHAR_W-1:0];
  assign txq.flush      = clr;

  // R9 status layout
  always_comb begin
    rd_word = 16'h0000;
    if (paddr == SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS) begin
      // R10 unused zero, except bit 3, which reads back as written
      rd_word = ctl & SSFP_TRANSMIT_CONTROL_AND_FLAGS_RW;
      rd_word[SSFP_TX_FILL]  = fill_sent_flag;
      rd_word[SSFP_TX_RXMON] = rx_in;
      rd_word[SSFP_TX_DONE]  = done;
    end else if (paddr == SSFP_RXSTAT_OFS) begin
      rd_word[7:0]          = rx_data;
      rd_word[SSFP_RX_PERR] = rx_perr;
      rd_word[SSFP_RX_DONE] = rx_done;
      rd_word[SSFP_RX_LOCK] = (rx_state == SSFP_RX_LOCKED);
    end
  end

  // read data is sampled in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= {16'h0000, rd_word};
      pslverr <= unmapped;
    end
  end

  // line parameters are write-only and return zero on read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_reg <= SSFP_PARAM_RST;
    end else if (clr) begin
      param_reg <= SSFP_PARAM_RST;
    end else if (wr_en && (paddr == SSFP_PARAM_OFS)) begin
      param_reg <= pwdata[15:0];
    end
  end

  // master clear wins over the value written with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= SSFP_TRANSMIT_CONTROL_AND_FLAGS_RST;
    end else if (clr) begin
      ctl <= SSFP_TRANSMIT_CONTROL_AND_FLAGS_RST;
    end else if (wr_en && (paddr == SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS)) begin
      ctl <= pwdata[15:0] & SSFP_TRANSMIT_CONTROL_AND_FLAGS_RW;
    end
  end

  // R8 clear on read
  // only a flag seen by the read is cleared, so a fill in between is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_sent_flag <= 1'b0;
    end else if (clr) begin
      fill_sent_flag <= 1'b0;
    end else if (fill_start) begin
      // R6 fill sets flag
      fill_sent_flag <= 1'b1;
    end else if (status_read_strobe && prdata[SSFP_TX_FILL]) begin
      fill_sent_flag <= 1'b0;
    end
  end

  // R13 done flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b1;
    end else if (clr || char_start) begin
      done <= 1'b1;
    end else if (wr_data && txq.push_ready) begin
      done <= 1'b0;
    end
  end

  // R7 fill irq
  // R14 done irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= (done && ctl[SSFP_TX_TXIE]) || (fill_sent_flag && ctl[SSFP_TX_FILLIE]);
    end
  end

  // two-stage synchronisers for the modem clock and receive pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      ss_prev <= 1'b0;
    end else begin
      mclk_s1 <= modem_clk;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
      rx_s1   <= rx_line;
      rx_s2   <= rx_s1;
      ss_prev <= ctl[SSFP_TX_SSCLK];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (div_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign div_tick = (div_cnt == DW'(BIT_CYCLES - 1));

  assign mode                = ssfp_mode_e'(param_reg[SSFP_PR_MODE +: 2]);
  assign wlen                = param_reg[SSFP_PR_WLEN +: 2];
  assign par_en              = param_reg[SSFP_PR_PEN];
  assign parity_sense_select = param_reg[SSFP_PR_PSEN];
  assign sync_char           = param_reg[SSFP_PR_SYNC +: 8];
  assign loop_mode_select    = ssfp_loop_e'(ctl[SSFP_TX_LOOP +: 2]);
  assign nbits = SSFP_MIN_BITS + {2'b00, wlen};
  assign flen  = nbits + {3'b000, par_en};
  assign fmask = 9'h1FF >> (SSFP_MAX_FRAME - flen);
  assign sync_mode = (mode == SSFP_MODE_INT) || (mode == SSFP_MODE_EXT);
  assign send_en   = ctl[SSFP_TX_SEND];

  // R12 mode clocking
  // R15 loop clocking
  // the internal and external loop modes step on the single-step bit; outside them mode 01 never steps
  always_comb begin
    bit_tick = 1'b0;
    if ((loop_mode_select == SSFP_LOOP_INT) || (loop_mode_select == SSFP_LOOP_EXT)) begin
      bit_tick = ctl[SSFP_TX_SSCLK] && !ss_prev;
    end else begin
      unique case (mode)
        SSFP_MODE_INT: bit_tick = div_tick;
        SSFP_MODE_ISO: bit_tick = div_tick;
        SSFP_MODE_EXT: bit_tick = mclk_s2 && !mclk_s3;
        SSFP_MODE_BAD: bit_tick = 1'b0;
      endcase
    end
  end

  // R15 receive source
  always_comb begin
    unique case (loop_mode_select)
      SSFP_LOOP_NORMAL: rx_in = rx_s2;
      SSFP_LOOP_INT:    rx_in = tx_line;
      SSFP_LOOP_EXT:    rx_in = ctl[SSFP_TX_MDATA];
      SSFP_LOOP_TEST:   rx_in = rx_s2;
    endcase
  end

  // R11 boundary only
  // a queued character is taken only when the previous frame is out
  assign boundary   = bit_tick && send_en && (tx_left == 4'h0) && !clr;
  assign char_start = boundary && txq.pop_valid;
  // R4 fill on underrun
  assign fill_start = boundary && !txq.pop_valid && sync_mode;
  assign txq.pop_ready = char_start;
  // R2 parity appended
  // R1 parity sense
  assign tx_frame   = ssfp_frame(txq.pop_valid ? txq.pop_data : sync_char, nbits,
                                 par_en, parity_sense_select);
  assign sync_frame = ssfp_frame(sync_char, nbits, par_en, parity_sense_select);

  // frames go out low bit first; line marks between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh   <= '0;
      tx_left <= 4'h0;
      tx_bit  <= 1'b1;
    end else if (clr || !send_en) begin
      tx_sh   <= '0;
      tx_left <= 4'h0;
      tx_bit  <= 1'b1;
    end else if (bit_tick) begin
      if (tx_left != 4'h0) begin
        tx_bit  <= tx_sh[0];
        tx_sh   <= {1'b0, tx_sh[8:1]};
        tx_left <= tx_left - 4'h1;
      end else if (char_start || fill_start) begin
        tx_bit  <= tx_frame[0];
        tx_sh   <= {1'b0, tx_frame[8:1]};
        tx_left <= flen - 4'h1;
      end else begin
        tx_bit  <= 1'b1;
      end
    end
  end

  // break holds the line at space without disturbing the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_line <= 1'b1;
    end else begin
      tx_line <= tx_bit && !ctl[SSFP_TX_BRK];
    end
  end

  // receiver: newest bit enters at the top of the window
  assign next_win = {rx_in, rx_win[8:1]};
  assign rx_frame = next_win >> (SSFP_MAX_FRAME - flen);
  assign par_mask = par_en ? (9'h001 << nbits) : 9'h000;
  // R3 sync compare
  assign rx_match = bit_tick && (rx_state == SSFP_RX_HUNT) && ((rx_frame & fmask) == sync_frame);
  assign rx_char  = bit_tick && (rx_state == SSFP_RX_LOCKED) && (rx_cnt == flen - 4'h1);

  // any write to receive status restarts the hunt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= SSFP_RX_HUNT;
      rx_win   <= 9'h1FF;
      rx_cnt   <= 4'h0;
    end else if (clr || (wr_en && (paddr == SSFP_RXSTAT_OFS))) begin
      rx_state <= SSFP_RX_HUNT;
      rx_win   <= 9'h1FF;
      rx_cnt   <= 4'h0;
    end else if (bit_tick) begin
      rx_win <= next_win;
      unique case (rx_state)
        SSFP_RX_HUNT: begin
          if (rx_match) begin
            rx_state <= SSFP_RX_LOCKED;
            rx_cnt   <= 4'h0;
          end
        end
        SSFP_RX_LOCKED: begin
          rx_cnt <= rx_char ? 4'h0 : rx_cnt + 4'h1;
        end
      endcase
    end
  end

  // R1 parity check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 8'h00;
      rx_perr <= 1'b0;
    end else if (clr) begin
      rx_data <= 8'h00;
      rx_perr <= 1'b0;
    end else if (rx_char) begin
      rx_data <= rx_frame[7:0] & fmask[7:0] & ~par_mask[7:0];
      rx_perr <= par_en && ((rx_frame & fmask) !=
                 ssfp_frame(rx_frame[7:0], nbits, par_en, parity_sense_select));
    end
  end

  // a new character wins over the read that clears the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_done <= 1'b0;
    end else if (clr) begin
      rx_done <= 1'b0;
    end else if (rx_char) begin
      rx_done <= 1'b1;
    end else if (rxstat_read && prdata[SSFP_RX_DONE]) begin
      rx_done <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fill_sets_flag:  assert property (fill_start |=> fill_sent_flag) // R6
    else $error("fill sent but flag not set");
  chk_fill_sync_only:  assert property ($rose(fill_sent_flag) |-> $past(sync_mode)) // R6
    else $error("fill outside synchronous mode");
  chk_fill_irq:        assert property (fill_sent_flag && ctl[SSFP_TX_FILLIE] |=> tx_irq) // R7
    else $error("fill flag enabled but no irq");
  chk_done_irq:        assert property (done && ctl[SSFP_TX_TXIE] |=> tx_irq) // R14
    else $error("done enabled but no irq");
  chk_read_clears:     assert property (status_read_strobe && prdata[SSFP_TX_FILL] && !fill_start
                                        && !clr |=> !fill_sent_flag) // R8
    else $error("status read did not clear fill flag");
  chk_done_start:      assert property (char_start |=> done) // R13
    else $error("done not set at character start");
  chk_done_load:       assert property (wr_data && txq.push_ready && !char_start && !clr
                                        |=> !done) // R13
    else $error("load did not clear done");
  chk_parity_sense:    assert property ((char_start || fill_start) && par_en |->
                                        ((^(tx_frame & fmask)) == ~parity_sense_select)) // R1
    else $error("parity sense wrong");
  chk_unused_zero:     assert property (acc && !pwrite && (paddr == SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS) |->
                                        (prdata[9] == 1'b0) && (prdata[2:1] == 2'b00)) // R10
    else $error("unused status bits not zero");
  chk_hunt_lock:       assert property (rx_match && !clr && !wr_en |=>
                                        (rx_state == SSFP_RX_LOCKED)) // R3
    else $error("sync match did not lock receiver");
  chk_bad_mode_idle:   assert property ((mode == SSFP_MODE_BAD) && (loop_mode_select ==
                                        SSFP_LOOP_NORMAL) |-> !bit_tick) // R12
    else $error("erroneous mode stepped the line");

  cov_fill:      cover property (fill_start);
  cov_char:      cover property (char_start ##[1:300] char_start);
  cov_lock:      cover property (rx_char && !rx_perr);
  cov_read_clr:  cover property (status_read_strobe && prdata[SSFP_TX_FILL]);
endmodule // ssfp_top
`default_nettype wire

// >>> verification/ssfp_modem_model.sv
// partner: synchronous modem with its own bit clock and a line echo
`timescale 1ns/1ps
`default_nettype none
module ssfp_modem_model (
  input  wire logic run,
  input  wire logic tx_line,
  output logic      modem_clk,
  output logic      rx_line
);
  // bit clock runs only while the modem is up, 160 ns period
  initial begin
    modem_clk = 1'b0;
    forever #80 modem_clk = run ? ~modem_clk : 1'b0;
  end
  // echo lets the receiver hunt the sync that our own transmitter sends
  assign rx_line = tx_line;
endmodule // ssfp_modem_model
`default_nettype wire

// >>> verification/ssfp_top_tb.sv
// testbench: apb register, fill, parity and loop checks of the sync serial block
`timescale 1ns/1ps
`default_nettype none
module ssfp_top_tb;
  import ssfp_pkg::*;
  localparam int BC = 16;
  logic        pclk, presetn, psel, penable, pwrite, modem_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, modem_clk, rx_line, tx_line, tx_irq, err;
  logic [15:0] seed;
  logic [17:0] bits;
  logic [31:0] lpw [4] = '{32'h0801, 32'h0800, 32'h5000, 32'h1000};
  logic        lpe [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int          mismatches, samples_checked, wt, mw;

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ssfp_top #(.BIT_CYCLES(BC), .FIFO_DEPTH(SSFP_FIFO_DEPTH)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modem_clk(modem_clk), .rx_line(rx_line),
    .tx_line(tx_line), .tx_irq(tx_irq));

  ssfp_modem_model modem (.run(modem_run), .tx_line(tx_line), .modem_clk(modem_clk),
    .rx_line(rx_line));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic par(input logic [7:0] d, input logic sen);
    return sen ? ^d : ~^d;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      chk(32'h1, 32'h0, "wait bound used up");
      tally_and_finish();
    end
  endtask

  // one transfer; an idle edge after it keeps drivers from double assignment
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    bound((pready === 1'b1) ? 0 : n, 200);
    rd = prdata;
    err = pslverr;
    wt = n;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] msk,
                       input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd & msk, exp, m);
  endtask

  task automatic frame(input logic sen, input logic [7:0] c, input logic [7:0] s);
    int n;
    n = 0;
    apb(1'b1, SSFP_PARAM_OFS, {18'h0, 4'hF, 1'b1, sen, s});
    apb(1'b1, SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h0000_0050);
    repeat (20 * BC) @(posedge pclk);
    apb(1'b1, SSFP_TXDATA_OFS, {24'h0, c});
    @(posedge pclk);
    while (tx_irq !== 1'b1 && n < 40 * BC) begin
      @(posedge pclk);
      n++;
    end
    bound(n, 40 * BC);
    // sample mid-bit so a cycle or two of latency does not matter
    repeat (BC / 2) @(posedge pclk);
    for (int i = 0; i < 18; i++) begin
      bits[i] = tx_line;
      repeat (BC) @(posedge pclk);
    end
    chk(32'(bits[7:0]), 32'(c), "data bits");
    chk(32'(bits[8]), 32'(par(c, sen)), "data parity");
    chk(32'(bits[16:9]), 32'(s), "fill char");
    chk(32'(bits[17]), 32'(par(s, sen)), "fill parity");
    rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h8080, 32'h8080, "fill and done");
    rdchk(SSFP_RXSTAT_OFS, 32'h0400, 32'h0400, "sync lock");
    $display("test frame sense %0d done", sen);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    modem_run = 1'b0;
    seed = 16'h0029;
    mismatches = 0;
    samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // the echoed line idles at mark, so the receive monitor reads one
    rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'hFFFF_FFFF, 32'h0000_0480, "reset value");
    apb(1'b1, SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'hFFFF_FEFF);
    rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'hFFFF_FBFF, 32'h0000_78F9, "layout");
    chk(32'(tx_irq), 32'h1, "done irq");
    apb(1'b1, SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h0000_0100);
    rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'hFFFF_FFFF, 32'h0000_0080, "master clear");
    chk(32'(tx_irq), 32'h0, "irq masked");
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[31:1], err}, 32'h1, "unmapped");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, lpw[i]);
      repeat (4) @(posedge pclk);
      rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h0400, {21'h0, lpe[i], 10'h0}, "rx monitor");
    end
    $display("test registers done");
    apb(1'b1, SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h0000_0030);
    repeat (30 * BC) @(posedge pclk);
    rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h8000, 32'h0, "no fill when iso");
    apb(1'b1, SSFP_PARAM_OFS, 32'h0000_1000);
    apb(1'b1, SSFP_TXDATA_OFS, 32'h0000_0055);
    repeat (30 * BC) @(posedge pclk);
    rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h8080, 32'h0, "bad mode idle");
    modem_run <= 1'b1;
    apb(1'b1, SSFP_PARAM_OFS, 32'h0000_2000 | 32'(seed[7:0]));
    repeat (300) @(posedge pclk);
    chk(32'(tx_irq), 32'h1, "fill irq");
    apb(1'b1, SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h0000_0020);
    rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h8000, 32'h8000, "fill in ext sync");
    rdchk(SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h8000, 32'h0, "read clears");
    @(posedge pclk);
    chk(32'(tx_irq), 32'h0, "fill irq drop");
    modem_run <= 1'b0;
    $display("test fill flag done");
    // back-pressure: more writes than the fifo holds must stall
    apb(1'b1, SSFP_PARAM_OFS, 32'h0000_3F00);
    apb(1'b1, SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h0000_0010);
    mw = 0;
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      apb(1'b1, SSFP_TXDATA_OFS, {24'h0, seed[7:0]});
      mw = (wt > mw) ? wt : mw;
    end
    chk(32'(mw > 1), 32'h1, "fifo stall");
    $display("test fifo done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, SSFP_TRANSMIT_CONTROL_AND_FLAGS_OFS, 32'h0000_0100);
      seed = lfsr(seed);
      frame(k[0], seed[7:0], seed[15:8]);
    end
    tally_and_finish();
  end
endmodule // ssfp_top_tb
`default_nettype wire
